// ===== hdl/oepc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module oepc_ctrl
  import oepc_pkg::*;
#(
  parameter int PULSE_US   = PULSE_US_NOM,
  parameter int MAX_PULSE  = MAX_PULSES
) (
  input  wire logic              clk,
  input  wire logic              reset,
  // user command side
  input  wire logic              cmd_valid,
  input  wire logic [1:0]        cmd_op,
  input  wire logic [ADDR_W-1:0] cmd_addr,
  input  wire logic [DATA_W-1:0] cmd_wdata,
  output logic                   busy_r,
  output logic                   done_r,
  output logic                   fail_r,
  output logic [DATA_W-1:0]      rdata_r,
  output logic [4:0]             pulses_r,
  // memory pins
  output logic [ADDR_W-1:0]      mem_addr_r,
  output logic                   chip_sel_n_r,
  output logic                   out_gate_n_r,
  output logic                   program_strobe_low_r,
  output logic                   vpp_raise_r,
  output logic                   address_bit_nine_raise_r,
  output logic [DATA_W-1:0]      data_out_r,
  output logic                   data_oe_n_r,
  input  wire logic [DATA_W-1:0] data_in
);
  initial begin
    if (PULSE_US < 1 || PULSE_US * OVER_FACTOR * MAX_PULSE >= (1 << TIMER_W))
      $error("pulse length does not fit the timer");
    if (MAX_PULSE < 1 || MAX_PULSE > 31) $error("pulse limit out of range");
  end
  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0000,
    ST_SETUP  = 4'b0001,
    ST_PULSE  = 4'b0010,
    ST_HOLD   = 4'b0011,
    ST_VERIFY = 4'b0100,
    ST_CHECK  = 4'b0101,
    ST_ACCESS = 4'b0110,
    ST_DONE   = 4'b0111
  } oepc_state_t;
  oepc_state_t st_r, st_nxt;
  logic [ADDR_W-1:0]  addr_nxt;
  logic [DATA_W-1:0]  wdata_r, wdata_nxt, dout_nxt, rdata_nxt;
  logic               ce_n_nxt, oe_n_nxt, pgm_nxt, vpp_nxt, a9_nxt, doe_n_nxt;
  logic               busy_nxt, done_nxt, fail_nxt, over_r, over_nxt;
  logic [4:0]         pulses_nxt;
  logic [3:0]         acc_r, acc_nxt;
  logic               tload;
  logic [TIMER_W-1:0] tload_us;
  logic               texp;
  localparam logic [3:0]         ACC_LAST = 4'(ACCESS_CYC - 1);
  localparam logic [TIMER_W-1:0] SETUP_T  = TIMER_W'(SETUP_US);
  localparam logic [TIMER_W-1:0] HOLD_T   = TIMER_W'(HOLD_US);
  localparam logic [TIMER_W-1:0] PULSE_T  = TIMER_W'(PULSE_US);
  localparam logic [4:0]         PMAX     = 5'(MAX_PULSE);
  // ***************************************************
  // interval timer
  // ***************************************************
  oepc_timer #(.TW(TIMER_W)) u_timer (
    .clk     (clk),
    .reset   (reset),
    .load    (tload),
    .load_us (tload_us),
    .expired (texp)
  );
  // ***************************************************
  // mode sequencer
  // ***************************************************
  // pins only move between states, so every level is steady for a whole phase
  always_comb begin
    st_nxt     = st_r;
    addr_nxt   = mem_addr_r;
    wdata_nxt  = wdata_r;
    dout_nxt   = data_out_r;
    rdata_nxt  = rdata_r;
    ce_n_nxt   = chip_sel_n_r;
    oe_n_nxt   = out_gate_n_r;
    pgm_nxt    = program_strobe_low_r;
    vpp_nxt    = vpp_raise_r;
    a9_nxt     = address_bit_nine_raise_r;
    doe_n_nxt  = data_oe_n_r;
    busy_nxt   = busy_r;
    done_nxt   = 1'b0;
    fail_nxt   = fail_r;
    over_nxt   = over_r;
    pulses_nxt = pulses_r;
    acc_nxt    = 4'h0;
    tload      = 1'b0;
    tload_us   = SETUP_T;
    case (st_r)
      ST_IDLE: begin
        if (cmd_valid) begin
          busy_nxt   = 1'b1;
          fail_nxt   = 1'b0;
          over_nxt   = 1'b0;
          pulses_nxt = 5'h00;
          wdata_nxt  = cmd_wdata;
          if (cmd_op == OEPC_OP_PROG) begin
            addr_nxt  = cmd_addr;
            dout_nxt  = cmd_wdata;
            doe_n_nxt = 1'b0;
            vpp_nxt   = 1'b1;
            pgm_nxt   = 1'b0;
            tload     = 1'b1;
            st_nxt    = ST_SETUP;
          end else if (cmd_op == OEPC_OP_SIG) begin
            // only bit zero may follow the request, the rest sit low
            addr_nxt = {{(ADDR_W-1){1'b0}}, cmd_addr[0]};
            a9_nxt   = 1'b1;
            ce_n_nxt = 1'b0;
            oe_n_nxt = 1'b0;
            st_nxt   = ST_ACCESS;
          end else begin
            addr_nxt = cmd_addr;
            ce_n_nxt = 1'b0;
            oe_n_nxt = 1'b0;
            st_nxt   = ST_ACCESS;
          end
        end
      end
      ST_SETUP: begin
        if (texp) begin
          ce_n_nxt   = 1'b0;
          tload      = 1'b1;
          // overprogram scales with the pulses the byte needed
          tload_us   = over_r ? TIMER_W'(PULSE_T * TIMER_W'(OVER_FACTOR) * TIMER_W'(pulses_r))
                              : PULSE_T;
          pulses_nxt = over_r ? pulses_r : pulses_r + 5'h01;
          st_nxt     = ST_PULSE;
        end
      end
      ST_PULSE: begin
        if (texp) begin
          ce_n_nxt = 1'b1;
          tload    = 1'b1;
          tload_us = HOLD_T;
          st_nxt   = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (texp) begin
          doe_n_nxt = 1'b1;
          pgm_nxt   = 1'b1;
          oe_n_nxt  = 1'b0;
          st_nxt    = ST_VERIFY;
        end
      end
      ST_VERIFY: begin
        acc_nxt = acc_r + 4'h1;
        if (acc_r == ACC_LAST) begin
          rdata_nxt = data_in;
          st_nxt    = ST_CHECK;
        end
      end
      ST_CHECK: begin
        oe_n_nxt = 1'b1;
        if (rdata_r == wdata_r && !over_r) begin
          over_nxt  = 1'b1;
          doe_n_nxt = 1'b0;
          pgm_nxt   = 1'b0;
          tload     = 1'b1;
          st_nxt    = ST_SETUP;
        end else if (rdata_r != wdata_r && !over_r && pulses_r != PMAX) begin
          doe_n_nxt = 1'b0;
          pgm_nxt   = 1'b0;
          tload     = 1'b1;
          st_nxt    = ST_SETUP;
        end else begin
          fail_nxt = (rdata_r != wdata_r);
          vpp_nxt  = 1'b0;
          st_nxt   = ST_DONE;
        end
      end
      ST_ACCESS: begin
        acc_nxt = acc_r + 4'h1;
        if (acc_r == ACC_LAST) begin
          rdata_nxt = data_in;
          ce_n_nxt  = 1'b1;
          oe_n_nxt  = 1'b1;
          a9_nxt    = 1'b0;
          st_nxt    = ST_DONE;
        end
      end
      ST_DONE: begin
        busy_nxt = 1'b0;
        done_nxt = 1'b1;
        st_nxt   = ST_IDLE;
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
  end
  // reset parks the part in standby with the supply low and the bus floating
  always_ff @(posedge clk) begin
    if (reset) begin
      st_r                     <= ST_IDLE;
      mem_addr_r               <= '0;
      wdata_r                  <= BLANK_BYTE;
      data_out_r               <= BLANK_BYTE;
      rdata_r                  <= BLANK_BYTE;
      chip_sel_n_r             <= 1'b1;
      out_gate_n_r             <= 1'b1;
      program_strobe_low_r     <= 1'b1;
      vpp_raise_r              <= 1'b0;
      address_bit_nine_raise_r <= 1'b0;
      data_oe_n_r              <= 1'b1;
      busy_r                   <= 1'b0;
      done_r                   <= 1'b0;
      fail_r                   <= 1'b0;
      over_r                   <= 1'b0;
      pulses_r                 <= 5'h00;
      acc_r                    <= 4'h0;
    end else begin
      st_r                     <= st_nxt;
      mem_addr_r               <= addr_nxt;
      wdata_r                  <= wdata_nxt;
      data_out_r               <= dout_nxt;
      rdata_r                  <= rdata_nxt;
      chip_sel_n_r             <= ce_n_nxt;
      out_gate_n_r             <= oe_n_nxt;
      program_strobe_low_r     <= pgm_nxt;
      vpp_raise_r              <= vpp_nxt;
      address_bit_nine_raise_r <= a9_nxt;
      data_oe_n_r              <= doe_n_nxt;
      busy_r                   <= busy_nxt;
      done_r                   <= done_nxt;
      fail_r                   <= fail_nxt;
      over_r                   <= over_nxt;
      pulses_r                 <= pulses_nxt;
      acc_r                    <= acc_nxt;
    end
  end
  // ***************************************************
  // checks
  // ***************************************************
  // helper: cycles select has been low during a supply-raised pulse
  logic [21:0] low_cnt_r;
  always_ff @(posedge clk) begin
    if (reset) low_cnt_r <= '0;
    else if (!chip_sel_n_r) low_cnt_r <= low_cnt_r + 22'h1;
    else low_cnt_r <= '0;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_pulse_end;
    vpp_raise_r && $rose(chip_sel_n_r);
  endsequence
  a_no_contention: assert property (!out_gate_n_r |-> data_oe_n_r)
    else $error("bus driven while gate low");
  a_prog_levels: assert property (!chip_sel_n_r && vpp_raise_r |-> !data_oe_n_r && !program_strobe_low_r)
    else $error("program pulse without data or strobe");
  a_verify_levels: assert property (st_r == ST_VERIFY |-> !out_gate_n_r && chip_sel_n_r && vpp_raise_r)
    else $error("verify levels wrong");
  a_sig_raise: assert property ($rose(address_bit_nine_raise_r) |-> address_bit_nine_raise_r [*8])
    else $error("bit nine dropped early");
  a_sig_addr: assert property (address_bit_nine_raise_r |-> mem_addr_r[ADDR_W-1:1] == '0 && !out_gate_n_r)
    else $error("signature address not clear");
  a_init_pulse: assert property (s_pulse_end ##0 !over_r |-> $past(low_cnt_r) >= 22'(PULSE_US * US_CYC)
                                 && $past(low_cnt_r) <= 22'(PULSE_US * US_CYC + 2))
    else $error("initial pulse width wrong");
  a_over_pulse: assert property (s_pulse_end ##0 over_r |->
                                 $past(low_cnt_r) >= 22'(PULSE_US * US_CYC * OVER_FACTOR) * 22'(pulses_r))
    else $error("overprogram pulse too short");
  a_retry_bound: assert property (st_r == ST_CHECK && !over_r && rdata_r != wdata_r && pulses_r != PMAX
                                  |=> st_r == ST_SETUP ##1 !over_r)
    else $error("failed verify not retried");
endmodule // oepc_ctrl
`default_nettype wire

// ===== hdl/oepc_pkg.sv
package oepc_pkg;
  // ***************************************************
  // timing
  // ***************************************************
  localparam int CLK_NS        = 40;
  localparam int ACCESS_NS     = 300;   // slowest speed grade access delay
  localparam int ACCESS_CYC    = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int US_NS         = 1000;
  localparam int US_CYC        = US_NS / CLK_NS;
  localparam int SETUP_US      = 2;     // address, data and supply set-up
  localparam int HOLD_US       = 2;     // data hold after the pulse
  localparam int PULSE_US_NOM  = 1000;  // nominal initial pulse
  localparam int OVER_FACTOR   = 3;     // overprogram = 3 x pulses used
  localparam int MAX_PULSES    = 25;
  localparam int TIMER_W       = 17;
  // ***************************************************
  // pin widths and commands
  // ***************************************************
  localparam int ADDR_W        = 15;
  localparam int DATA_W        = 8;
  localparam logic [DATA_W-1:0] BLANK_BYTE = 8'hFF;
  typedef enum logic [1:0] {
    OEPC_OP_READ = 2'b00,
    OEPC_OP_PROG = 2'b01,
    OEPC_OP_SIG  = 2'b10
  } oepc_op_t;
endpackage : oepc_pkg

// ===== hdl/oepc_timer.sv
`timescale 1ns/1ps
`default_nettype none
module oepc_timer
  import oepc_pkg::*;
#(
  parameter int TW = TIMER_W
) (
  input  wire logic          clk,
  input  wire logic          reset,
  input  wire logic          load,
  input  wire logic [TW-1:0] load_us,
  output logic               expired
);
  initial begin
    if (TW < 2) $error("timer width too small");
  end
  logic [TW-1:0] cnt_r, cnt_nxt;
  logic [7:0]    div_r, div_nxt;
  logic          run_r, run_nxt;
  logic          exp_r, exp_nxt;
  localparam logic [7:0] DIV_LAST = 8'(US_CYC - 1);
  // ***************************************************
  // microsecond enable divider and down counter
  // ***************************************************
  // divider restarts on load so every interval is an exact multiple
  always_comb begin
    cnt_nxt = cnt_r;
    div_nxt = div_r;
    run_nxt = run_r;
    exp_nxt = 1'b0;
    if (load) begin
      cnt_nxt = load_us;
      div_nxt = 8'h00;
      run_nxt = (load_us != '0);
      exp_nxt = (load_us == '0);
    end else if (run_r) begin
      if (div_r == DIV_LAST) begin
        div_nxt = 8'h00;
        if (cnt_r == TW'(1)) begin
          run_nxt = 1'b0;
          exp_nxt = 1'b1;
        end
        cnt_nxt = cnt_r - TW'(1);
      end else begin
        div_nxt = div_r + 8'h01;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_r <= '0;
      div_r <= 8'h00;
      run_r <= 1'b0;
      exp_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      div_r <= div_nxt;
      run_r <= run_nxt;
      exp_r <= exp_nxt;
    end
  end
  assign expired = exp_r;
endmodule // oepc_timer
`default_nettype wire

// ===== tb/oepc_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module oepc_mem_model
  import oepc_pkg::*;
#(
  parameter logic [7:0] MAKER_ID = 8'h5A, // arbitrary value
  parameter logic [7:0] TYPE_ID  = 8'hC3, // arbitrary value
  parameter int         ACC      = 6
) (
  input  wire logic              clk,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic              chip_sel_n,
  input  wire logic              out_gate_n,
  input  wire logic              strobe_n,
  input  wire logic              vpp,
  input  wire logic              sig_mode,
  input  wire logic [DATA_W-1:0] din,
  input  wire logic              din_oe_n,
  input  wire logic [5:0]        need_pulses,
  output logic      [DATA_W-1:0] dout
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [DATA_W-1:0] last;
  logic              sel_d;
  logic              drive;
  int                glow;
  int                cnt;

  // ***************************************************
  // cell array
  // ***************************************************
  // a blank part reads all ones
  initial begin
    for (int i = 0; i < (1 << ADDR_W); i++) mem[i] = BLANK_BYTE;
    last = 8'h00;
    sel_d = 1'b1;
    glow = 0;
    cnt = 0;
  end

  // a cell only takes a byte at the end of a select pulse; slow parts need several
  always @(posedge clk) begin
    last <= dout;
    sel_d <= chip_sel_n;
    glow <= out_gate_n ? 0 : glow + 1;
    if (!vpp) cnt <= 0;
    else if (chip_sel_n && !sel_d && !strobe_n && !din_oe_n) begin
      cnt <= cnt + 1;
      if (cnt + 1 >= need_pulses) mem[addr] <= mem[addr] & din;
    end
  end

  // ***************************************************
  // output pins
  // ***************************************************
  // released pins toggle so a late sample never looks valid
  always_comb begin
    drive = !out_gate_n && (!chip_sel_n || vpp);
    if (!drive || glow < ACC) dout = ~last;
    else if (sig_mode && !chip_sel_n) dout = addr[0] ? TYPE_ID : MAKER_ID;
    else dout = mem[addr];
  end
endmodule // oepc_mem_model
`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import oepc_pkg::*;
;
  localparam int         PULSE = 2;
  localparam int         MAXP  = 4;
  localparam int         PW    = PULSE * US_CYC;
  localparam logic [7:0] MAKER = 8'h5A; // arbitrary value
  localparam logic [7:0] TYPEB = 8'hC3; // arbitrary value
  typedef struct {logic [7:0] rd; logic fl; logic [4:0] pl; bit prog;} oepc_note_t;

  logic              clk;
  logic              reset;
  logic              cmd_valid;
  logic [1:0]        cmd_op;
  logic [ADDR_W-1:0] cmd_addr;
  logic [DATA_W-1:0] cmd_wdata;
  logic              busy_r, done_r, fail_r;
  logic [DATA_W-1:0] rdata_r, data_out_r, data_in;
  logic [4:0]        pulses_r;
  logic [ADDR_W-1:0] mem_addr_r;
  logic              chip_sel_n_r, out_gate_n_r, program_strobe_low_r;
  logic              vpp_raise_r, address_bit_nine_raise_r, data_oe_n_r;
  logic [5:0]        need_pulses;
  logic [7:0]        shadow [logic [14:0]];
  oepc_note_t        notes [$];
  oepc_note_t        mon_nt;
  int                n_errors = 0;
  int                samples_checked = 0;
  int                wid = 0;
  int                i;
  int unsigned       seed;
  logic [14:0]       pa;

  oepc_ctrl #(.PULSE_US(PULSE), .MAX_PULSE(MAXP)) i_oepc_ctrl (
    .clk(clk), .reset(reset), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .busy_r(busy_r), .done_r(done_r), .fail_r(fail_r), .rdata_r(rdata_r),
    .pulses_r(pulses_r), .mem_addr_r(mem_addr_r), .chip_sel_n_r(chip_sel_n_r),
    .out_gate_n_r(out_gate_n_r), .program_strobe_low_r(program_strobe_low_r),
    .vpp_raise_r(vpp_raise_r), .address_bit_nine_raise_r(address_bit_nine_raise_r),
    .data_out_r(data_out_r), .data_oe_n_r(data_oe_n_r), .data_in(data_in));

  oepc_mem_model #(.MAKER_ID(MAKER), .TYPE_ID(TYPEB)) i_oepc_mem_model (
    .clk(clk), .addr(mem_addr_r), .chip_sel_n(chip_sel_n_r), .out_gate_n(out_gate_n_r),
    .strobe_n(program_strobe_low_r), .vpp(vpp_raise_r), .sig_mode(address_bit_nine_raise_r),
    .din(data_out_r), .din_oe_n(data_oe_n_r), .need_pulses(need_pulses), .dout(data_in));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ***************************************************
  // checking
  // ***************************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // expected result is noted before the request; a stray completion finds no note
  always @(posedge clk) begin
    if (done_r === 1'b1) begin
      if (notes.size() == 0) check(16'hDEAD, 16'h0000);
      else begin
        mon_nt = notes.pop_front();
        if (mon_nt.prog) begin
          check({15'h0, fail_r}, {15'h0, mon_nt.fl});
          check({11'h0, pulses_r}, {11'h0, mon_nt.pl});
          check({15'h0, busy_r}, 16'h0);
        end
        else check({8'h0, rdata_r}, {8'h0, mon_nt.rd});
      end
    end
  end

  // pulse widths scale with PULSE; short ones are initial, long ones overprogram
  always @(posedge clk) begin
    if (vpp_raise_r === 1'b1 && chip_sel_n_r === 1'b0) wid <= wid + 1;
    else if (wid != 0) begin
      if (wid < 2 * PW) check(16'(wid * 100 >= 95 * PW && wid * 100 <= 105 * PW), 16'h1);
      else check(16'(wid * 100 >= 285 * PW && wid * 100 <= 7875 * PW), 16'h1);
      wid <= 0;
    end
    if (address_bit_nine_raise_r === 1'b1) check({2'h0, mem_addr_r[14:1]}, 16'h0);
  end

  // ***************************************************
  // stimulus
  // ***************************************************
  // spam keeps a program request up while busy; it must be ignored
  task automatic run(input logic [1:0] op, input logic [14:0] a, input logic [7:0] d,
                     input int need, input bit spam);
    oepc_note_t nt;
    logic [7:0] old;
    int n;
    old = shadow.exists(a) ? shadow[a] : BLANK_BYTE;
    nt = '{rd: old, fl: 1'b0, pl: 5'h0, prog: op == OEPC_OP_PROG};
    if (op == OEPC_OP_SIG) nt.rd = a[0] ? TYPEB : MAKER;
    if (nt.prog) begin
      nt.fl = !(need <= MAXP && (old & d) == d);
      nt.pl = nt.fl ? 5'(MAXP) : 5'(need);
      if (need <= MAXP) shadow[a] = old & d;
    end
    notes.push_back(nt);
    need_pulses = 6'(need);
    @(posedge clk);
    #1;
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_addr = a;
    cmd_wdata = d;
    @(posedge clk);
    #1;
    cmd_op = OEPC_OP_PROG;
    if (spam) begin
      repeat (3) @(posedge clk);
      #1;
    end
    cmd_valid = 1'b0;
    for (n = 0; n < 20000 && done_r !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    // a command that never completes ends the run as a failure
    if (done_r !== 1'b1) begin
      n_errors++;
      conclude();
    end
  endtask

  initial begin
    cmd_valid = 1'b0;
    cmd_op = 2'h0;
    cmd_addr = 15'h0;
    cmd_wdata = 8'h00;
    need_pulses = 6'h1;
    reset = 1'b1;
    seed = $urandom(32'h29A6);
    repeat (10) @(posedge clk);
    #1;
    reset = 1'b0;
    // blank reads, the spare opcode reads too
    run(OEPC_OP_READ, 15'($urandom), 8'h00, 1, 1'b1);
    run(2'h3, 15'($urandom), 8'h00, 1, 1'b0);
    // both identity bytes with junk on the upper address bits
    run(OEPC_OP_SIG, {14'($urandom), 1'b0}, 8'h00, 1, 1'b0);
    run(OEPC_OP_SIG, {14'($urandom), 1'b1}, 8'h00, 1, 1'b0);
    // cells needing 1, 3 and 5 pulses; the last passes the retry limit
    pa = 15'($urandom);
    for (i = 0; i < 3; i++) begin
      // bit zero kept clear so a blank cell can never already match
      run(OEPC_OP_PROG, pa + 15'(i), 8'($urandom) & 8'hFE, i * 2 + 1, 1'b0);
      run(OEPC_OP_READ, pa + 15'(i), 8'h00, 1, 1'b0);
    end
    // asking for ones over cleared bits cannot succeed
    run(OEPC_OP_PROG, pa, 8'($urandom) | 8'h81, 1, 1'b0);
    run(OEPC_OP_READ, pa, 8'h00, 1, 1'b0);
    // let the monitor take the last note before the verdict
    @(posedge clk);
    #1;
    check(16'(notes.size()), 16'h0);
    conclude();
  end

  // whole run needs a few thousand cycles, well under this span
  initial begin
    #800000;
    n_errors++;
    conclude();
  end
endmodule // tb_top
`default_nettype wire
